/* verilog/bwu_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bwu_regs.svh"

module bwu_top
#(
  parameter int NCMP  = 4,
  parameter int NSCR  = 8,
  parameter int NCORE = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest,
  input  wire logic              cfg_select,
  input  wire logic              debug_mode,
  input  wire logic              pc_valid,
  input  wire logic [2:0]        pc_core,
  input  wire logic [31:0]       pc_value,
  input  wire logic              mem_valid,
  input  wire logic              mem_store,
  input  wire logic [2:0]        mem_core,
  input  wire logic [31:0]       mem_address,
  input  wire logic              res_valid,
  input  wire logic [2:0]        res_core,
  input  wire logic [31:0]       res_id,
  output var  logic              debug_irq,
  output var  logic [2:0]        debug_cause,
  output var  logic [1:0]        debug_index,
  output var  logic [31:0]       debug_data
);

  // ******************************************************
  // storage
  // ******************************************************
  logic [31:0]           scratch [NSCR];
  logic [31:0]           ib_addr [NCMP];
  logic [31:0]           ib_ctrl [NCMP];
  logic [31:0]           dw_first [NCMP];
  logic [31:0]           dw_second [NCMP];
  logic [31:0]           dw_ctrl [NCMP];
  logic [31:0]           rw_mask [NCMP];
  logic [31:0]           rw_value [NCMP];
  logic [31:0]           rw_ctrl [NCMP];
  bwu_pkg::bwu_bus_t     bus_phase;
  logic [7:0]            idx;
  logic [31:0]           wmask;
  logic                  wr_ok;
  logic [NCMP-1:0]       ib_hit;
  logic [NCMP-1:0]       dw_hit;
  logic [NCMP-1:0]       rw_hit;
  logic [31:0]           next_rdata;
  logic [2:0]            next_cause;
  logic [1:0]            next_index;
  logic [31:0]           next_data;
  logic                  hit_take;

  // ******************************************************
  // write decode
  // ******************************************************
  // the two low address bits are ignored; every register is a word
  assign idx = avs_address[9:2];
  // byte lanes to bit mask
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // one write per request, taken on the done edge only; outside debug
  // mode the write is still acknowledged, so software never stalls
  assign wr_ok = avs_write && (bus_phase == bwu_pkg::BWU_DONE)
                 && debug_mode;

  // ******************************************************
  // bus slave: one wait state on every access
  // ******************************************************
  // waitrequest comes from a flop, never straight from the request;
  // the price is one wait state on every access
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_phase       <= bwu_pkg::BWU_IDLE;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      unique case (bus_phase)
        bwu_pkg::BWU_IDLE:
        begin
          // a request seen while idle is answered on the next edge
          if (avs_read || avs_write)
          begin
            bus_phase       <= bwu_pkg::BWU_DONE;
            avs_waitrequest <= 1'b0;
          end
        end
        bwu_pkg::BWU_DONE:
        begin
          // the master drops its request on this edge
          bus_phase       <= bwu_pkg::BWU_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ******************************************************
  // read mux
  // ******************************************************
  // unmapped words read zero; the register ranges never overlap, so
  // the order of the tests below does not matter
  always_comb
  begin
    next_rdata = `BWU_UNMAPPED_DATA;
    if (idx >= `BWU_IDX_SCRATCH && idx < `BWU_IDX_SCRATCH + 8'(NSCR))
      next_rdata = scratch[3'(idx - `BWU_IDX_SCRATCH)];
    else if (idx == `BWU_IDX_CAUSE)
      next_rdata = {14'h0000, debug_index, 13'h0000, debug_cause};
    else if (idx == `BWU_IDX_CAUSE_DATA)
      next_rdata = debug_data;
    for (int i = 0; i < NCMP; i++)
    begin
      if (idx == `BWU_IDX_IBRK_ADDR + 8'(i))
        next_rdata = ib_addr[i];
      if (idx == `BWU_IDX_IBRK_CTRL + 8'(i))
        next_rdata = ib_ctrl[i];
      if (idx == `BWU_IDX_DW_FIRST + 8'(i))
        next_rdata = dw_first[i];
      if (idx == `BWU_IDX_DW_SECOND + 8'(i))
        next_rdata = dw_second[i];
      if (idx == `BWU_IDX_DW_CTRL + 8'(i))
        next_rdata = dw_ctrl[i];
      if (idx == `BWU_IDX_RW_MASK + 8'(i))
        next_rdata = rw_mask[i];
      if (idx == `BWU_IDX_RW_VALUE + 8'(i))
        next_rdata = rw_value[i];
      if (idx == `BWU_IDX_RW_CTRL + 8'(i))
        next_rdata = rw_ctrl[i];
    end
  end

  // read data registered so it is valid with waitrequest low
  // held until the next read; a write leaves it alone
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h00000000;
    else if (bus_phase == bwu_pkg::BWU_IDLE && avs_read)
      avs_readdata <= next_rdata;
  end

  // ******************************************************
  // scratch words, no reset
  // ******************************************************
  // cfg_select is not decoded at all; both views hit the same words,
  // so a write through either view is seen through the other
  always_ff @(posedge clk_sys)
  begin
    for (int s = 0; s < NSCR; s++)
      if (wr_ok && idx == `BWU_IDX_SCRATCH + 8'(s))
        scratch[s] <= (scratch[s] & ~wmask) | (avs_writedata & wmask);
  end

  // ******************************************************
  // comparator data registers, no reset
  // ******************************************************
  // left without reset to save flops; software loads them before it
  // sets any enable bit, and a clear enable masks whatever they hold
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NCMP; i++)
    begin
      if (wr_ok && idx == `BWU_IDX_IBRK_ADDR + 8'(i))
        ib_addr[i] <= (ib_addr[i] & ~wmask) | (avs_writedata & wmask);
      if (wr_ok && idx == `BWU_IDX_DW_FIRST + 8'(i))
        dw_first[i] <= (dw_first[i] & ~wmask) | (avs_writedata & wmask);
      if (wr_ok && idx == `BWU_IDX_DW_SECOND + 8'(i))
        dw_second[i] <= (dw_second[i] & ~wmask) | (avs_writedata & wmask);
      if (wr_ok && idx == `BWU_IDX_RW_MASK + 8'(i))
        rw_mask[i] <= (rw_mask[i] & ~wmask) | (avs_writedata & wmask);
      if (wr_ok && idx == `BWU_IDX_RW_VALUE + 8'(i))
        rw_value[i] <= (rw_value[i] & ~wmask) | (avs_writedata & wmask);
    end
  end

  // ******************************************************
  // control words, reset to zero, reserved bits stay zero
  // ******************************************************
  // enables clear on reset so nothing fires before software sets up;
  // a write merges byte lanes first, then the mask clears reserved bits
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NCMP; i++)
      begin
        ib_ctrl[i] <= `BWU_CTRL_RESET;
        dw_ctrl[i] <= `BWU_CTRL_RESET;
        rw_ctrl[i] <= `BWU_CTRL_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NCMP; i++)
      begin
        if (wr_ok && idx == `BWU_IDX_IBRK_CTRL + 8'(i))
          ib_ctrl[i] <= ((ib_ctrl[i] & ~wmask) | (avs_writedata & wmask))
                        & `BWU_IBRK_CTRL_MASK;
        if (wr_ok && idx == `BWU_IDX_DW_CTRL + 8'(i))
          dw_ctrl[i] <= ((dw_ctrl[i] & ~wmask) | (avs_writedata & wmask))
                        & `BWU_DW_CTRL_MASK;
        if (wr_ok && idx == `BWU_IDX_RW_CTRL + 8'(i))
          rw_ctrl[i] <= ((rw_ctrl[i] & ~wmask) | (avs_writedata & wmask))
                        & `BWU_RW_CTRL_MASK;
      end
    end
  end

  // ******************************************************
  // comparators
  // ******************************************************
  // each comparator works alone; inputs come from the tile clock domain,
  // so they feed the compare directly with no synchroniser
  // a core number is the bit position inside the enable field
  // the range compare is unsigned; with first above second the inside
  // range is empty and the outside range covers every address
  always_comb
  begin
    for (int i = 0; i < NCMP; i++)
    begin
      ib_hit[i] = pc_valid && ib_ctrl[i][`BWU_CTRL_EN]
        && ib_ctrl[i][`BWU_CTRL_MASK_LO + pc_core]
        && ((pc_value == ib_addr[i])
            ^ ib_ctrl[i][`BWU_CTRL_INV]);
      dw_hit[i] = mem_valid && dw_ctrl[i][`BWU_CTRL_EN]
        && dw_ctrl[i][`BWU_CTRL_MASK_LO + mem_core]
        && (mem_store || dw_ctrl[i][`BWU_CTRL_LOAD])
        && (dw_ctrl[i][`BWU_CTRL_INV]
            ? (mem_address < dw_first[i]
               || mem_address > dw_second[i])
            : (mem_address >= dw_first[i]
               && mem_address <= dw_second[i]));
      rw_hit[i] = res_valid && rw_ctrl[i][`BWU_CTRL_EN]
        && rw_ctrl[i][`BWU_CTRL_MASK_LO + res_core]
        && (((res_id & rw_mask[i]) == rw_value[i])
            ^ rw_ctrl[i][`BWU_CTRL_INV]);
    end
  end

  // ******************************************************
  // cause report; priority instruction, data, resource
  // ******************************************************
  always_comb
  begin
    next_cause = 3'h0;
    next_index = 2'h0;
    next_data  = 32'h00000000;
    // classes run lowest priority first, so a later class overwrites
    // descending loop leaves the lowest index
    for (int i = NCMP - 1; i >= 0; i--)
    begin
      if (rw_hit[i])
      begin
        next_cause = `BWU_CAUSE_RW;
        next_index = 2'(i);
        next_data  = res_id;
      end
    end
    for (int i = NCMP - 1; i >= 0; i--)
    begin
      if (dw_hit[i])
      begin
        next_cause = `BWU_CAUSE_DW;
        next_index = 2'(i);
        next_data  = mem_address;
      end
    end
    for (int i = NCMP - 1; i >= 0; i--)
    begin
      if (ib_hit[i])
      begin
        next_cause = `BWU_CAUSE_IBRK;
        next_index = 2'(i);
        next_data  = 32'h00000000;
      end
    end
  end

  // a hit counts only outside debug mode, so the debugger's own
  // work never overwrites the report that it is reading
  assign hit_take = (next_cause != 3'h0) && !debug_mode;

  // ******************************************************
  // debug interrupt
  // ******************************************************
  // one cycle per hit cycle; never stretched, so each hit cycle gives
  // the pipeline exactly one request
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      debug_irq <= 1'b0;
    else
      debug_irq <= hit_take;
  end

  // ******************************************************
  // cause report, held until the next hit
  // ******************************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      debug_cause <= 3'h0;
      debug_index <= 2'h0;
      debug_data  <= 32'h00000000;
    end
    else if (hit_take)
    begin
      debug_cause <= next_cause;
      debug_index <= next_index;
      debug_data  <= next_data;
    end
  end

endmodule
`default_nettype wire

/* verilog/bwu_regs.svh */
`ifndef BWU_REGS_SVH
`define BWU_REGS_SVH

// register indices; byte address is four times the index
`define BWU_IDX_SCRATCH    8'h20
`define BWU_IDX_IBRK_ADDR  8'h30
`define BWU_IDX_IBRK_CTRL  8'h40
`define BWU_IDX_DW_FIRST   8'h50
`define BWU_IDX_DW_SECOND  8'h60
`define BWU_IDX_DW_CTRL    8'h70
`define BWU_IDX_RW_MASK    8'h80
`define BWU_IDX_RW_VALUE   8'h90
`define BWU_IDX_RW_CTRL    8'h9c
// own registers: debug cause report
`define BWU_IDX_CAUSE      8'ha0
`define BWU_IDX_CAUSE_DATA 8'ha1

// control word fields
`define BWU_CTRL_EN        0
`define BWU_CTRL_INV       1
`define BWU_CTRL_LOAD      2
`define BWU_CTRL_MASK_LO   16
`define BWU_CTRL_MASK_HI   23
`define BWU_IBRK_CTRL_MASK 32'h00ff0003
`define BWU_DW_CTRL_MASK   32'h00ff0007
`define BWU_RW_CTRL_MASK   32'h00ff0003
`define BWU_CTRL_RESET     32'h00000000

// cause codes and report fields
`define BWU_CAUSE_IBRK     3'h3
`define BWU_CAUSE_DW       3'h4
`define BWU_CAUSE_RW       3'h5
`define BWU_CAUSE_IDX_LO   16
`define BWU_UNMAPPED_DATA  32'h00000000

`endif

/* verilog/bwu_pkg.sv */
package bwu_pkg;
  // bus slave phase
  typedef enum logic [0:0]
  {
    BWU_IDLE = 1'b0,
    BWU_DONE = 1'b1
  } bwu_bus_t;
endpackage

/* testbench/bwu_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// handshake and hit report checks
// ****************************************
module bwu_checker
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        debug_mode,
  input wire logic        pc_valid,
  input wire logic        mem_valid,
  input wire logic [31:0] mem_address,
  input wire logic        res_valid,
  input wire logic [31:0] res_id,
  input wire logic        debug_irq,
  input wire logic [2:0]  debug_cause,
  input wire logic [31:0] debug_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // one wait state, then a single-cycle acknowledge
  ack_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("acknowledge not after one wait");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge held too long");
  idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("acknowledge without request");
  // hits are ignored while the tile sits in debug mode
  dbg_quiet_a: assert property (debug_mode |=> !debug_irq)
    else $error("hit taken in debug mode");
  no_source_a: assert property (!pc_valid && !mem_valid && !res_valid
    |=> !debug_irq) else $error("hit without any access");
  irq_cause_a: assert property (debug_irq |-> debug_cause inside
    {3'h3, 3'h4, 3'h5}) else $error("bad cause code");
  // captured word follows the class of the winning comparator
  instr_hit_a: assert property (debug_irq && debug_cause == 3'h3
    |-> $past(pc_valid) && debug_data == 32'h0) else $error("bad instr hit");
  data_hit_a: assert property (debug_irq && debug_cause == 3'h4
    |-> $past(mem_valid) && debug_data == $past(mem_address))
    else $error("bad data capture");
  res_hit_a: assert property (debug_irq && debug_cause == 3'h5
    |-> $past(res_valid) && debug_data == $past(res_id))
    else $error("bad resource capture");
  cover property (debug_irq && debug_cause == 3'h3);
  cover property (debug_irq && debug_cause == 3'h4);
  cover property (debug_irq && debug_cause == 3'h5);
endmodule
`default_nettype wire

/* testbench/bwu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pipeline side: one-cycle access samples
// ****************************************
module bwu_core_model
(
  input  wire logic        clk_sys,
  output var  logic        pc_valid = 1'b0,
  output var  logic [2:0]  pc_core = 3'h0,
  output var  logic [31:0] pc_value = 32'h0,
  output var  logic        mem_valid = 1'b0,
  output var  logic        mem_store = 1'b0,
  output var  logic [2:0]  mem_core = 3'h0,
  output var  logic [31:0] mem_address = 32'h0,
  output var  logic        res_valid = 1'b0,
  output var  logic [2:0]  res_core = 3'h0,
  output var  logic [31:0] res_id = 32'h0
);
  // kind 0 fetch, 1 memory, 2 resource; busy values flip once idle
  // so a stale word never looks like a fresh access
  task automatic send(input int k, input logic s, input logic [2:0] c,
                      input logic [31:0] v);
    @(posedge clk_sys);
    pc_valid <= (k == 0);
    mem_valid <= (k == 1);
    res_valid <= (k == 2);
    mem_store <= s;
    {pc_core, mem_core, res_core} <= {3{c}};
    {pc_value, mem_address, res_id} <= {3{v}};
    @(posedge clk_sys);
    {pc_valid, mem_valid, res_valid} <= 3'h0;
    {pc_value, mem_address, res_id} <= {3{~v}};
  endtask
endmodule
`default_nettype wire

/* testbench/bwu_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end
module bwu_top_tb;
  logic        clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, cfg_select = 1'b0, debug_mode = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [31:0] debug_data, pc_value, mem_address, res_id;
  logic [2:0]  debug_cause, pc_core, mem_core, res_core;
  logic [1:0]  debug_index;
  logic        avs_waitrequest, debug_irq, pc_valid, mem_valid, mem_store;
  logic        res_valid;
  int          n_fail = 0, checks = 0;

  // tile clock, 25 ns
  always #12.5 clk_sys = ~clk_sys;

  bwu_top i_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .cfg_select, .debug_mode, .pc_valid, .pc_core, .pc_value, .mem_valid,
    .mem_store, .mem_core, .mem_address, .res_valid, .res_core, .res_id,
    .debug_irq, .debug_cause, .debug_index, .debug_data);
  bwu_core_model i_core (.clk_sys, .pc_valid, .pc_core, .pc_value,
    .mem_valid, .mem_store, .mem_core, .mem_address, .res_valid,
    .res_core, .res_id);

  // bus access held until acknowledge is sampled; data taken at that edge
  task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= {i, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest);
    rdata = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    acc(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    acc(1'b0, i, 32'h0);
    `CHK(rdata, e)
  endtask
  task automatic dm(input logic v);
    @(posedge clk_sys);
    debug_mode <= v;
  endtask
  // one access from the pipeline; the irq pulse stands one cycle,
  // so it is sampled at the edge that ends it
  task automatic tst(input int k, input logic s, input logic [2:0] c,
                     input logic [31:0] v, input logic e, input logic [1:0] x);
    i_core.send(k, s, c, v);
    @(posedge clk_sys);
    `CHK(debug_irq, e)
    if (e)
    begin
      `CHK(debug_cause, 3'(k + 3))
      `CHK(debug_index, x)
      `CHK(debug_data, (k == 0) ? 32'h0 : v)
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a full run takes far less than this span
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h40 + 8'(i), 32'h0);
      rd(8'h70 + 8'(i), 32'h0);
      rd(8'h9c + 8'(i), 32'h0);
    end
    wr(8'h41, 32'hffffffff);
    rd(8'h41, 32'h0);
    dm(1'b1);
    wr(8'h41, 32'hffffffff);
    rd(8'h41, 32'h00ff0003);
    wr(8'h71, 32'hffffffff);
    rd(8'h71, 32'h00ff0007);
    wr(8'h9d, 32'hffffffff);
    rd(8'h9d, 32'h00ff0003);
    // scratch written through one view, read back through the other
    for (int i = 0; i < 8; i++)
    begin
      cfg_select <= i[0];
      wr(8'h20 + 8'(i), 32'h5a000000 + i);
    end
    for (int i = 0; i < 8; i++)
    begin
      cfg_select <= !i[0];
      rd(8'h20 + 8'(i), 32'h5a000000 + i);
    end
    rd(8'h10, 32'h0);
    wr(8'h71, 32'h0);
    wr(8'h9d, 32'h0);
    wr(8'h30, 32'h1000);
    wr(8'h31, 32'h1000);
    wr(8'h41, 32'h00020001);
    wr(8'h52, 32'h100);
    wr(8'h62, 32'h1ff);
    wr(8'h72, 32'h00010001);
    wr(8'h83, 32'hff);
    wr(8'h93, 32'h42);
    wr(8'h9f, 32'h00800001);
    tst(0, 1'b0, 3'h1, 32'h1000, 1'b0, 2'h0);
    dm(1'b0);
    tst(0, 1'b0, 3'h1, 32'h1000, 1'b1, 2'h1);
    tst(0, 1'b0, 3'h0, 32'h1000, 1'b0, 2'h0);
    tst(0, 1'b0, 3'h1, 32'h1004, 1'b0, 2'h0);
    tst(1, 1'b1, 3'h0, 32'h100, 1'b1, 2'h2);
    tst(1, 1'b1, 3'h0, 32'h1ff, 1'b1, 2'h2);
    tst(1, 1'b1, 3'h0, 32'h200, 1'b0, 2'h0);
    tst(1, 1'b0, 3'h0, 32'h150, 1'b0, 2'h0);
    tst(2, 1'b0, 3'h7, 32'h1242, 1'b1, 2'h3);
    rd(8'ha0, 32'h00030005);
    rd(8'ha1, 32'h1242);
    tst(2, 1'b0, 3'h7, 32'h43, 1'b0, 2'h0);
    dm(1'b1);
    wr(8'h40, 32'h00020003);
    wr(8'h41, 32'h00020003);
    wr(8'h72, 32'h00010007);
    wr(8'h9f, 32'h00800003);
    dm(1'b0);
    tst(0, 1'b0, 3'h1, 32'h1000, 1'b0, 2'h0);
    tst(0, 1'b0, 3'h1, 32'h1004, 1'b1, 2'h0);
    tst(1, 1'b0, 3'h0, 32'h0ff, 1'b1, 2'h2);
    tst(1, 1'b1, 3'h0, 32'h100, 1'b0, 2'h0);
    tst(1, 1'b1, 3'h0, 32'h200, 1'b1, 2'h2);
    tst(2, 1'b0, 3'h7, 32'h43, 1'b1, 2'h3);
    tst(2, 1'b0, 3'h7, 32'h1242, 1'b0, 2'h0);
    dm(1'b1);
    wr(8'h9f, 32'h00800002);
    dm(1'b0);
    tst(2, 1'b0, 3'h7, 32'h43, 1'b0, 2'h0);
    give_verdict();
  end
endmodule

bind bwu_top bwu_checker i_chk (.clk_sys(clk_sys), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .debug_mode(debug_mode),
  .pc_valid(pc_valid), .mem_valid(mem_valid), .mem_address(mem_address),
  .res_valid(res_valid), .res_id(res_id), .debug_irq(debug_irq),
  .debug_cause(debug_cause), .debug_data(debug_data));
`default_nettype wire
